// ---- include/card_access_params.svh ----
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 10 MHz system clock
// Notes: Register indices are word offsets on the two host ports
`ifndef CARD_ACCESS_PARAMS_SVH
`define CARD_ACCESS_PARAMS_SVH
`define REG_SPEED_DETECT 2'h0
`define REG_RESET_READY 2'h1
`define REG_CTRL_BACKPLANE 2'h2
`define REG_CTRL_PROCESSOR 2'h3
`define RESET_LSB 0
`define READY_LSB 8
`define SWAP_LSB 8
`define PACK_LSB 24
`define BCAST_LSB 0
`define HOLD_LSB 18
`define IDLE_LSB 16
`define RESET_INIT 8'hff
`define CLK_PERIOD_NS 100
`define HOLD_250_NS 250
`define HOLD_500_NS 500
`define HOLD_1000_NS 1000
`define HOLD_2000_NS 2000
`define IDLE_50_NS 50
`define IDLE_100_NS 100
`define IDLE_200_NS 200
// Least times round up, never below one cycle
`define CYC_UP(t) (((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SPEED_STD 2'h2
`define SPEED_RSVD 2'h3
`endif

// ---- include/card_access_pkg.sv ----
// Purpose: Shared types of the card access controller
// Assumes: Nothing
// Notes: Numbers live in the params header
package card_access_pkg;
    typedef enum logic {owner_backplane, owner_processor} owner_t;
    typedef enum logic [1:0] {half_idle, half_first, half_second} half_t;
endpackage

// ---- hdl/card_write_fifo.sv ----
// Purpose: Posted write queue toward the cards
// Assumes: Single clock, synchronous use
// Notes: Read data registered; depth a power of two
`timescale 1ns/1ps
module card_write_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic clock_en,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic empty
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
    logic [AW:0] count;
    logic push;
    logic pop;
    assign count = wr_ptr - rd_ptr;
    assign in_ready = (count != DEPTH[AW:0]);
    assign empty = (count == '0) && !out_valid;
    assign push = in_valid && in_ready && clock_en;
    // Output register refills whenever empty or being drained
    assign pop = clock_en && (count != '0) && (!out_valid || out_ready);
    always_ff @(posedge clock) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            wr_ptr <= '0;
        end else if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
        end
    end
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            rd_ptr <= '0;
        end else if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
        end
    end
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            out_valid <= 1'b0;
            out_data <= '0;
        end else if (clock_en) begin
            if (pop) begin
                out_valid <= 1'b1;
                out_data <= mem[rd_ptr[AW-1:0]];
            end else if (out_ready) begin
                out_valid <= 1'b0;
            end
        end
    end
endmodule

// ---- hdl/card_access_controller.sv ----
// Purpose: Card access controller between backplane host and processor host
// Assumes: One 10 MHz clock; card status pins are asynchronous
// Notes: Posted writes pass an 8-word queue before reaching the cards
// Operation
// - Speed status register holds two bits per card, card 8 at top
// - Speed codes 00 single, 01 double, 10 standard or empty; 11 never
// - Ready bits for cards 1..8 sit in the upper byte of reset register
// - Per-card reset bits in low byte reset to all ones
// - Writing one asserts the card reset line at once
// - Writing zero keeps reset until queued posted writes are flushed
// - Shared flush monitor; pending releases clear together after later queue drains
// - Owner keeps contended card for hold time from grant, then other side
// - Backplane hold code picks 250ns, 500ns, 1us or 2us; reads back
// - Processor hold field same coding; on expiry card goes to backplane
// - After backplane idle time, processor request takes card without hold wait
// - Idle code picks 0, 50ns, 100ns or 200ns
// - Processor idle field alike; backplane then takes card on request
// - Backplane swap bit puts first half-word high, else low
// - Processor pack bit splits one 32-bit cycle into two card cycles
// - Processor swap only with pack and single-width window, same ordering
// - Broadcast write goes simultaneously to all masked cards
`timescale 1ns/1ps
`include "card_access_params.svh"
module card_access_controller #(
    parameter int CARDS = 8,
    parameter int QDEPTH = 8
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic clock_en,
    input wire logic bp_reg_wr,
    input wire logic bp_reg_rd,
    input wire logic [1:0] bp_reg_index,
    input wire logic [31:0] bp_reg_wdata,
    output logic [31:0] bp_reg_rdata,
    input wire logic pr_reg_wr,
    input wire logic pr_reg_rd,
    input wire logic [1:0] pr_reg_index,
    input wire logic [31:0] pr_reg_wdata,
    output logic [31:0] pr_reg_rdata,
    input wire logic [CARDS-1:0] bp_card_req,
    input wire logic [CARDS-1:0] pr_card_req,
    output logic [CARDS-1:0] card_owner_processor,
    input wire logic wr_valid,
    output logic wr_ready,
    input wire logic wr_from_processor,
    input wire logic wr_broadcast,
    input wire logic wr_wide,
    input wire logic [2:0] wr_card,
    input wire logic [31:0] wr_data,
    output logic [CARDS-1:0] card_wr_strobe,
    output logic [15:0] card_wr_data,
    input wire logic [2*CARDS-1:0] card_speed_pins,
    input wire logic [CARDS-1:0] card_ready_pins,
    output logic [CARDS-1:0] card_reset_ctrl
);
    logic [2*CARDS-1:0] speed_s1, speed_s2;
    logic [CARDS-1:0] ready_s1, ready_s2;
    logic [CARDS-1:0] reset_req;
    logic [CARDS-1:0] release_pend;
    logic [CARDS-1:0] halfword_swap;
    logic [CARDS-1:0] processor_swap;
    logic [CARDS-1:0] processor_pack_enable;
    logic [CARDS-1:0] broadcast_select;
    logic [1:0] hold_guarantee_time, idle_handover_time;
    logic [1:0] pr_hold_time, processor_idle_handover_time;
    logic [2*CARDS-1:0] speed_shown;
    logic [31:0] reg_speed, reg_reset, reg_ctrl_bp, reg_ctrl_pr;
    logic [4:0] bp_idle_cnt, pr_idle_cnt;
    logic q_out_valid, q_out_ready, q_empty;
    logic [37:0] q_out, q_in;
    card_access_pkg::half_t half_state;
    logic [CARDS-1:0] next_strobe;

    function automatic logic [4:0] hold_cycles(input logic [1:0] code);
        unique case (code)
            2'h0: hold_cycles = 5'(`CYC_UP(`HOLD_250_NS));
            2'h1: hold_cycles = 5'(`CYC_UP(`HOLD_500_NS));
            2'h2: hold_cycles = 5'(`CYC_UP(`HOLD_1000_NS));
            2'h3: hold_cycles = 5'(`CYC_UP(`HOLD_2000_NS));
        endcase
    endfunction
    function automatic logic [4:0] idle_cycles(input logic [1:0] code);
        unique case (code)
            2'h0: idle_cycles = 5'h0;
            2'h1: idle_cycles = 5'(`CYC_UP(`IDLE_50_NS));
            2'h2: idle_cycles = 5'(`CYC_UP(`IDLE_100_NS));
            2'h3: idle_cycles = 5'(`CYC_UP(`IDLE_200_NS));
        endcase
    endfunction

    // Card status pins are asynchronous
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            speed_s1 <= '0;
            speed_s2 <= '0;
            ready_s1 <= '0;
            ready_s2 <= '0;
        end else if (clock_en) begin
            speed_s1 <= card_speed_pins;
            speed_s2 <= speed_s1;
            ready_s1 <= card_ready_pins;
            ready_s2 <= ready_s1;
        end
    end

    genvar g;
    generate
        for (g = 0; g < CARDS; g++) begin : gen_speed
            // Reserved code shown as standard speed
            assign speed_shown[2*g+1:2*g] = (speed_s2[2*g+1:2*g] == `SPEED_RSVD) ? `SPEED_STD
                : speed_s2[2*g+1:2*g];
        end
    endgenerate

    assign reg_speed = {16'h0, speed_shown};
    assign reg_reset = {16'h0, ready_s2, reset_req};
    assign reg_ctrl_bp = {12'h0, hold_guarantee_time, idle_handover_time, halfword_swap, 8'h0};
    assign reg_ctrl_pr = {processor_pack_enable, 4'h0, pr_hold_time, processor_idle_handover_time,
        processor_swap, broadcast_select};
    assign card_reset_ctrl = reset_req;

    function automatic logic [31:0] reg_mux(input logic [1:0] idx, input logic [31:0] a,
        input logic [31:0] b, input logic [31:0] c, input logic [31:0] d);
        unique case (idx)
            `REG_SPEED_DETECT: reg_mux = a;
            `REG_RESET_READY: reg_mux = b;
            `REG_CTRL_BACKPLANE: reg_mux = c;
            `REG_CTRL_PROCESSOR: reg_mux = d;
        endcase
    endfunction

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            bp_reg_rdata <= '0;
            pr_reg_rdata <= '0;
        end else if (clock_en) begin
            if (bp_reg_rd) begin
                bp_reg_rdata <= reg_mux(bp_reg_index, reg_speed, reg_reset, reg_ctrl_bp, reg_ctrl_pr);
            end
            if (pr_reg_rd) begin
                pr_reg_rdata <= reg_mux(pr_reg_index, reg_speed, reg_reset, reg_ctrl_bp, reg_ctrl_pr);
            end
        end
    end

    // Only the backplane side writes its control register
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            hold_guarantee_time <= 2'h0;
            idle_handover_time <= 2'h0;
            halfword_swap <= '0;
        end else if (clock_en && bp_reg_wr && bp_reg_index == `REG_CTRL_BACKPLANE) begin
            hold_guarantee_time <= bp_reg_wdata[`HOLD_LSB+:2];
            idle_handover_time <= bp_reg_wdata[`IDLE_LSB+:2];
            halfword_swap <= bp_reg_wdata[`SWAP_LSB+:CARDS];
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            processor_pack_enable <= '0;
            pr_hold_time <= 2'h0;
            processor_idle_handover_time <= 2'h0;
            processor_swap <= '0;
            broadcast_select <= '0;
        end else if (clock_en && pr_reg_wr && pr_reg_index == `REG_CTRL_PROCESSOR) begin
            processor_pack_enable <= pr_reg_wdata[`PACK_LSB+:CARDS];
            pr_hold_time <= pr_reg_wdata[`HOLD_LSB+:2];
            processor_idle_handover_time <= pr_reg_wdata[`IDLE_LSB+:2];
            processor_swap <= pr_reg_wdata[`SWAP_LSB+:CARDS];
            broadcast_select <= pr_reg_wdata[`BCAST_LSB+:CARDS];
        end
    end

    // Reset bits; either host may write. Queue monitor is shared, not per card.
    logic rst_wr;
    logic [CARDS-1:0] rst_wdata;
    assign rst_wr = (bp_reg_wr && bp_reg_index == `REG_RESET_READY)
        || (pr_reg_wr && pr_reg_index == `REG_RESET_READY);
    assign rst_wdata = (bp_reg_wr && bp_reg_index == `REG_RESET_READY) ? bp_reg_wdata[`RESET_LSB+:CARDS]
        : pr_reg_wdata[`RESET_LSB+:CARDS];
    // A later release restarts the flush of the queue as it then stands
    logic [3:0] flush_left;
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            reset_req <= `RESET_INIT;
            release_pend <= '0;
            flush_left <= '0;
        end else if (clock_en) begin
            if (rst_wr) begin
                reset_req <= reset_req | rst_wdata;
                release_pend <= (release_pend | (reset_req & ~rst_wdata)) & ~rst_wdata;
                flush_left <= 4'(QDEPTH + 1);
            end else if (release_pend != '0) begin
                if (q_empty || flush_left == 4'h0) begin
                    reset_req <= reset_req & ~release_pend;
                    release_pend <= '0;
                end else if (q_out_valid && q_out_ready) begin
                    flush_left <= flush_left - 4'h1;
                end
            end
        end
    end

    // Idle counters per side saturate at 31 cycles, past the largest idle setting
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            bp_idle_cnt <= '0;
            pr_idle_cnt <= '0;
        end else if (clock_en) begin
            bp_idle_cnt <= (bp_card_req != '0) ? 5'h0 : (bp_idle_cnt == 5'h1f ? bp_idle_cnt : bp_idle_cnt + 5'h1);
            pr_idle_cnt <= (pr_card_req != '0) ? 5'h0 : (pr_idle_cnt == 5'h1f ? pr_idle_cnt : pr_idle_cnt + 5'h1);
        end
    end

    generate
        for (g = 0; g < CARDS; g++) begin : gen_arb
            card_access_pkg::owner_t owner;
            logic [4:0] held;
            logic bp_idle, pr_idle, to_pr, to_bp;
            // Idle time counted over the whole side, not per card
            assign bp_idle = bp_idle_cnt >= idle_cycles(idle_handover_time);
            assign pr_idle = pr_idle_cnt >= idle_cycles(processor_idle_handover_time);
            assign to_pr = owner == card_access_pkg::owner_backplane && pr_card_req[g]
                && (!bp_card_req[g] ? bp_idle : held >= hold_cycles(hold_guarantee_time));
            assign to_bp = owner == card_access_pkg::owner_processor && bp_card_req[g]
                && (!pr_card_req[g] ? pr_idle : held >= hold_cycles(pr_hold_time));
            always_ff @(posedge clock or posedge sys_rst) begin
                if (sys_rst) begin
                    owner <= card_access_pkg::owner_backplane;
                    held <= '0;
                end else if (clock_en) begin
                    if (to_pr || to_bp) begin
                        owner <= to_pr ? card_access_pkg::owner_processor : card_access_pkg::owner_backplane;
                        held <= 5'h0;
                    end else if (held != 5'h1f) begin
                        held <= held + 5'h1;
                    end
                end
            end
            assign card_owner_processor[g] = owner == card_access_pkg::owner_processor;
        end
    endgenerate

    // Queue word: source, broadcast, wide, card, data
    assign q_in = {wr_from_processor, wr_broadcast, wr_wide, wr_card, wr_data};
    card_write_fifo #(.WIDTH(38), .DEPTH(QDEPTH)) u_queue (
        .clock(clock),
        .sys_rst(sys_rst),
        .clock_en(clock_en),
        .in_valid(wr_valid),
        .in_ready(wr_ready),
        .in_data(q_in),
        .out_valid(q_out_valid),
        .out_ready(q_out_ready),
        .out_data(q_out),
        .empty(q_empty)
    );

    // Drain side: cards in reset stall nothing, their writes are dropped
    logic q_pr, q_bc, q_wide, split, swap_sel;
    logic [2:0] q_card;
    assign q_pr = q_out[37];
    assign q_bc = q_out[36];
    assign q_wide = q_out[35];
    assign q_card = q_out[34:32];
    assign split = !q_bc && q_wide && (q_pr ? processor_pack_enable[q_card] : 1'b1);
    assign swap_sel = q_pr ? processor_swap[q_card] : halfword_swap[q_card];
    assign q_out_ready = (half_state == card_access_pkg::half_second)
        || (half_state == card_access_pkg::half_idle && q_out_valid && !split);
    always_comb begin
        next_strobe = '0;
        if (q_out_valid && half_state != card_access_pkg::half_idle) begin
            next_strobe[q_card] = 1'b1;
        end else if (q_out_valid && q_bc) begin
            next_strobe = broadcast_select;
        end else if (q_out_valid) begin
            next_strobe[q_card] = 1'b1;
        end
    end
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            half_state <= card_access_pkg::half_idle;
            card_wr_strobe <= '0;
            card_wr_data <= '0;
        end else if (clock_en) begin
            card_wr_strobe <= next_strobe & ~reset_req;
            unique case (half_state)
                card_access_pkg::half_idle: begin
                    card_wr_data <= (split && swap_sel) ? q_out[31:16] : q_out[15:0];
                    if (q_out_valid && split) begin
                        half_state <= card_access_pkg::half_first;
                    end
                end
                card_access_pkg::half_first: begin
                    card_wr_data <= swap_sel ? q_out[15:0] : q_out[31:16];
                    half_state <= card_access_pkg::half_second;
                end
                card_access_pkg::half_second: begin
                    card_wr_strobe <= '0;
                    half_state <= card_access_pkg::half_idle;
                end
            endcase
        end
    end

    a_reserved_speed: assert property (@(posedge clock) disable iff (sys_rst)
        reg_speed[15:14] != 2'h3 && reg_speed[1:0] != 2'h3) else $error("reserved speed code shown");
    a_reset_init: assert property (@(posedge clock) $fell(sys_rst) |-> reset_req == 8'hff)
        else $error("reset bits not all ones after reset");
    a_reset_at_once: assert property (@(posedge clock) disable iff (sys_rst)
        (clock_en && bp_reg_wr && bp_reg_index == 2'h1) |=> (card_reset_ctrl & $past(bp_reg_wdata[7:0])) == $past(bp_reg_wdata[7:0]))
        else $error("reset not asserted at once");
    a_hold_until_flush: assert property (@(posedge clock) disable iff (sys_rst)
        ($fell(card_reset_ctrl[0]) && !$past(rst_wr)) |-> $past(q_empty || flush_left == 4'h0))
        else $error("reset released before queue flushed");
    a_joint_clear: assert property (@(posedge clock) disable iff (sys_rst)
        (clock_en && !rst_wr && release_pend != 8'h0 && (q_empty || flush_left == 4'h0))
        |=> (reset_req & $past(release_pend)) == 8'h0)
        else $error("pending releases not cleared together");
    a_bp_ctrl_only: assert property (@(posedge clock) disable iff (sys_rst)
        (pr_reg_wr && !(bp_reg_wr && bp_reg_index == 2'h2)) |=> $stable(hold_guarantee_time))
        else $error("processor changed backplane control");
    a_hold_respected: assert property (@(posedge clock) disable iff (sys_rst)
        (clock_en && gen_arb[0].owner == card_access_pkg::owner_backplane && bp_card_req[0] && pr_card_req[0]
        && gen_arb[0].held < hold_cycles(hold_guarantee_time)) |=> !card_owner_processor[0])
        else $error("card taken before hold time");
    a_broadcast_mask: assert property (@(posedge clock) disable iff (sys_rst)
        (clock_en && q_out_valid && q_bc && half_state == card_access_pkg::half_idle)
        |=> card_wr_strobe == ($past(broadcast_select) & ~$past(reset_req)))
        else $error("broadcast strobes differ from mask");
endmodule

// ---- bench/card_side_model.sv ----
// Purpose: Card side: speed and ready pins, capture of card cycles
// Assumes: Bench chooses fitted cards and speed codes
// Notes: A card held in reset never reports ready
`timescale 1ns/1ps
module card_side_model (
    input wire logic clock,
    input wire logic [7:0] card_wr_strobe,
    input wire logic [15:0] card_wr_data,
    input wire logic [7:0] card_reset_ctrl,
    input wire logic [15:0] speed_set,
    input wire logic [7:0] present,
    output logic [15:0] card_speed_pins,
    output logic [7:0] card_ready_pins
);
    logic [23:0] seen[$];
    // Codes come from the bench, reserved one included
    assign card_speed_pins = speed_set;
    assign card_ready_pins = present & ~card_reset_ctrl;
    // Kept in order so the bench can pair halves
    always @(posedge clock) begin
        if (|card_wr_strobe) begin
            seen.push_back({card_wr_strobe, card_wr_data});
        end
    end
endmodule

// ---- bench/function_card_access_controller_test.sv ----
// Purpose: Self-checking bench of the card access controller
// Assumes: Inputs change on the falling edge; reset held 12 cycles
// Notes: Fixed seed; card cycles are popped from the card model
`timescale 1ns/1ps
module function_card_access_controller_test;
    logic clock = 1'b0, sys_rst = 1'b1, clock_en = 1'b1, wr_ready;
    logic bp_reg_wr = 1'b0, bp_reg_rd = 1'b0, pr_reg_wr = 1'b0, pr_reg_rd = 1'b0;
    logic [1:0] bp_reg_index = 2'h0, pr_reg_index = 2'h0;
    logic [31:0] bp_reg_wdata = '0, pr_reg_wdata = '0, bp_reg_rdata, pr_reg_rdata, rd, bpw, prw, w;
    logic [7:0] bp_card_req = '0, pr_card_req = '0, card_owner_processor, card_wr_strobe, card_reset_ctrl;
    logic wr_valid = 1'b0, wr_from_processor = 1'b0, wr_broadcast = 1'b0, wr_wide = 1'b0;
    logic [2:0] wr_card = 3'h0;
    logic [31:0] wr_data = '0;
    logic [15:0] card_wr_data, card_speed_pins, speed_set = 16'haaaa;
    logic [7:0] card_ready_pins, present = 8'h00;
    logic [31:0] hist[32];
    logic [2:0] cs[32];
    int fails = 0, comparisons = 0, seed = 32'h2c6a, stalls = 0;

    card_access_controller #(.CARDS(8), .QDEPTH(8)) card_access_controller_inst (
        .clock, .sys_rst, .clock_en, .bp_reg_wr, .bp_reg_rd, .bp_reg_index, .bp_reg_wdata, .bp_reg_rdata,
        .pr_reg_wr, .pr_reg_rd, .pr_reg_index, .pr_reg_wdata, .pr_reg_rdata, .bp_card_req, .pr_card_req,
        .card_owner_processor, .wr_valid, .wr_ready, .wr_from_processor, .wr_broadcast, .wr_wide,
        .wr_card, .wr_data, .card_wr_strobe, .card_wr_data, .card_speed_pins, .card_ready_pins,
        .card_reset_ctrl);
    card_side_model card_side_model_inst (.clock, .card_wr_strobe, .card_wr_data, .card_reset_ctrl,
        .speed_set, .present, .card_speed_pins, .card_ready_pins);

    always #50 clock = ~clock;

    task automatic report_and_stop;
        $display("comparisons=%0d fails=%0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic stop_bad;
        fails++;
        $display("BAD t=%0t wait expired got=%h exp=%h", $time, 1'b0, 1'b1);
        report_and_stop();
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    function automatic logic [15:0] half(input logic [31:0] x, input bit sw, input bit second);
        return (sw ^ second) ? x[31:16] : x[15:0];
    endfunction

    // Reserved code reads back as standard speed
    function automatic logic [31:0] speed_exp(input logic [15:0] s);
        for (int j = 0; j < 8; j++)
            if (s[2*j +: 2] == 2'h3) s[2*j +: 2] = 2'h2;
        return {16'h0000, s};
    endfunction

    // Read data sampled two edges on, well after it settles
    task automatic reg_acc(input bit pr, input bit wr, input logic [1:0] idx, input logic [31:0] d);
        @(negedge clock);
        if (pr)
            {pr_reg_wr, pr_reg_rd, pr_reg_index, pr_reg_wdata} = {wr, !wr, idx, d};
        else
            {bp_reg_wr, bp_reg_rd, bp_reg_index, bp_reg_wdata} = {wr, !wr, idx, d};
        @(negedge clock);
        {pr_reg_wr, pr_reg_rd, bp_reg_wr, bp_reg_rd} = 4'h0;
        @(negedge clock);
        rd = pr ? pr_reg_rdata : bp_reg_rdata;
    endtask

    // Entered on a falling edge; valid stays up for the next call
    task automatic post(input bit pr, input bit bc, input bit wide, input logic [2:0] c, input logic [31:0] d);
        {wr_valid, wr_from_processor, wr_broadcast, wr_wide, wr_card, wr_data} = {1'b1, pr, bc, wide, c, d};
        for (int n = 0; wr_ready !== 1'b1; n++) begin
            if (n > 50) stop_bad();
            stalls++;
            @(negedge clock);
        end
        @(negedge clock);
    endtask

    task automatic pop(input logic [7:0] s, input logic [15:0] d);
        logic [23:0] got;
        for (int n = 0; card_side_model_inst.seen.size() == 0; n++) begin
            if (n > 50) stop_bad();
            @(negedge clock);
        end
        got = card_side_model_inst.seen.pop_front();
        chk({8'h00, got}, {8'h00, s, d});
    endtask

    task automatic burst(input int n, input logic [2:0] lim);
        stalls = 0;
        for (int i = 0; i < n; i++) begin
            cs[i] = 3'($random(seed)) & lim;
            hist[i] = $random(seed);
            post(1'b0, 1'b0, 1'b1, cs[i], hist[i]);
        end
        wr_valid = 1'b0;
    endtask

    task automatic drain(input int n);
        for (int i = 0; i < n; i++) begin
            pop(8'h01 << cs[i], half(hist[i], bpw[8+cs[i]], 1'b0));
            pop(8'h01 << cs[i], half(hist[i], bpw[8+cs[i]], 1'b1));
        end
    endtask

    task automatic poll_release;
        for (int n = 0; n < 40; n++) begin
            reg_acc(1'b0, 1'b0, 2'h1, '0);
            if (rd[7:0] === 8'h00) return;
        end
        stop_bad();
    endtask

    task automatic wait_owner(input int i, input logic v);
        for (int n = 0; card_owner_processor[i] !== v; n++) begin
            if (n > 12) stop_bad();
            @(negedge clock);
        end
    endtask

    initial begin
        repeat (12) @(posedge clock);
        @(negedge clock);
        sys_rst = 1'b0;
        chk(32'(card_reset_ctrl), 32'h0000_00ff);
        // Frozen clock enable must ignore a release
        clock_en = 1'b0;
        reg_acc(1'b0, 1'b1, 2'h1, '0);
        chk(32'(card_reset_ctrl), 32'h0000_00ff);
        clock_en = 1'b1;
        present = 8'($random(seed)) | 8'h01;
        for (int i = 0; i < 4; i++) begin
            for (int j = 0; j < 8; j++) speed_set[2*j +: 2] = 2'($random(seed));
            // Reserved code at both ends of the register once
            if (i == 0) speed_set = speed_set | 16'hc003;
            repeat (4) @(negedge clock);
            reg_acc(i[0], 1'b0, 2'h0, '0);
            chk(rd, speed_exp(speed_set));
        end
        reg_acc(1'b0, 1'b0, 2'h1, '0);
        chk(rd, 32'h0000_00ff);
        w = $random(seed);
        reg_acc(1'b0, 1'b1, 2'h2, w);
        reg_acc(1'b1, 1'b1, 2'h2, ~w);
        reg_acc(1'b1, 1'b0, 2'h2, '0);
        chk(rd, w & 32'h000f_ff00);
        reg_acc(1'b1, 1'b1, 2'h3, w);
        reg_acc(1'b0, 1'b1, 2'h3, ~w);
        reg_acc(1'b0, 1'b0, 2'h3, '0);
        chk(rd, w & 32'hff0f_ffff);
        // Shortest hold and idle codes keep the arbiter waits small
        bpw = $random(seed) & 32'h0000_ff00;
        prw = ($random(seed) & 32'hff00_ffff) | 32'h0000_0001;
        reg_acc(1'b0, 1'b1, 2'h2, bpw);
        reg_acc(1'b1, 1'b1, 2'h3, prw);
        reg_acc(1'b0, 1'b1, 2'h1, '0);
        poll_release();
        repeat (4) @(negedge clock);
        reg_acc(1'b1, 1'b0, 2'h1, '0);
        chk(rd, {16'h0000, present, 8'h00});
        burst(24, 3'h7);
        chk(32'(stalls > 0), 32'h1);
        drain(24);
        for (int c = 0; c < 8; c++) begin
            w = $random(seed);
            post(1'b1, 1'b0, 1'b1, 3'(c), w);
            wr_valid = 1'b0;
            pop(8'h01 << c, prw[24+c] ? half(w, prw[8+c], 1'b0) : w[15:0]);
            if (prw[24+c]) pop(8'h01 << c, half(w, prw[8+c], 1'b1));
        end
        post(1'b1, 1'b1, 1'b0, 3'h0, w);
        wr_valid = 1'b0;
        pop(prw[7:0], w[15:0]);
        reg_acc(1'b0, 1'b1, 2'h1, 32'h0000_0014);
        chk(32'(card_reset_ctrl), 32'h0000_0014);
        fork
            burst(16, 3'h0);
            begin
                repeat (3) @(negedge clock);
                reg_acc(1'b0, 1'b1, 2'h1, 32'h0000_0010);
                reg_acc(1'b0, 1'b0, 2'h1, '0);
                chk(32'(rd[7:0]), 32'h0000_0014);
                reg_acc(1'b0, 1'b1, 2'h1, '0);
            end
        join
        for (int n = 0; card_reset_ctrl[2] !== 1'b0; n++) begin
            if (n > 60) stop_bad();
            @(negedge clock);
        end
        chk(32'(card_reset_ctrl), 32'h0);
        drain(16);
        {bp_card_req, pr_card_req} = {8'h01, 8'h01};
        wait_owner(0, 1'b1);
        chk(32'(card_owner_processor), 32'h1);
        repeat (2) @(negedge clock);
        chk(32'(card_owner_processor[0]), 32'h1);
        wait_owner(0, 1'b0);
        {bp_card_req, pr_card_req} = {8'h00, 8'h04};
        wait_owner(2, 1'b1);
        {bp_card_req, pr_card_req} = {8'h04, 8'h00};
        wait_owner(2, 1'b0);
        report_and_stop();
    end
endmodule
